// >>> design/fsdc_defs.svh
// offsets, field positions, reset values and counts of the synthesizer control bank
`ifndef FSDC_DEFS_SVH
`define FSDC_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define FSDC_OFS_WORD_A 8'h00
`define FSDC_OFS_WORD_B 8'h04
`define FSDC_OFS_WORD_C 8'h08
`define FSDC_OFS_STATUS 8'h0c

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FSDC_PUMP_LSB 17
`define FSDC_NHI_LSB 14
`define FSDC_NUMHI_LSB 4
`define FSDC_DENLO_LSB 10
`define FSDC_RDIV_LSB 4
`define FSDC_HALVE_BIT 23
`define FSDC_WIDE_BIT 22
`define FSDC_SPREAD_LSB 20
`define FSDC_ORDER_LSB 18
`define FSDC_TSEL_LSB 14
`define FSDC_DENHI_LSB 4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define FSDC_WORD_A_RST 24'h200001
`define FSDC_WORD_B_RST 24'h400012
`define FSDC_WORD_C_RST 24'h040003
`define FSDC_FB_DIV_RST 12'h037

// ------------------------------------------------------------
// analog figures and lock detect counts
// ------------------------------------------------------------
`define FSDC_PUMP_UNIT_UA 11'd90
`define FSDC_LOCK_WIN 8'h02
`define FSDC_LOCK_CNT 4'h8

`endif

// >>> design/fsdc_pkg.sv
// types shared by the synthesizer control bank
package fsdc_pkg;

  typedef enum logic [3:0] {
    FSDC_TP_HIZ = 4'b0000,
    FSDC_TP_HIGH = 4'b0001,
    FSDC_TP_LOW = 4'b0010,
    FSDC_TP_DLOCK = 4'b0011,
    FSDC_TP_FBHALF = 4'b0101,
    FSDC_TP_ALOCK_OD = 4'b0110,
    FSDC_TP_ALOCK_PP = 4'b0111,
    FSDC_TP_REFOUT = 4'b1110
  } fsdc_tsel_t;

  typedef enum logic [1:0] {
    FSDC_ORD_FOURTH = 2'b00,
    FSDC_ORD_RESET = 2'b01,
    FSDC_ORD_SECOND = 2'b10,
    FSDC_ORD_THIRD = 2'b11
  } fsdc_order_t;

  typedef enum logic [1:0] {
    FSDC_SPR_WEAK = 2'b00,
    FSDC_SPR_RSVD = 2'b01,
    FSDC_SPR_STRONG = 2'b10,
    FSDC_SPR_OFF = 2'b11
  } fsdc_spread_t;

endpackage

// >>> design/fsdc_dsm.sv
// multi-stage delta-sigma modulator producing the divide offset
`timescale 1ns/1ps
`default_nettype none
module fsdc_dsm (
  input wire logic clk,
  input wire logic reset,
  input wire logic step,
  input wire logic [21:0] num,
  input wire logic [21:0] denom,
  input wire fsdc_pkg::fsdc_order_t ordr,
  input wire fsdc_pkg::fsdc_spread_t spread,
  output logic signed [4:0] offset
);
  import fsdc_pkg::*;

  logic [21:0] acc_r [4];
  logic [21:0] acc_nxt [4];
  logic [3:0] cy;
  logic c2d_r, c3d_r, c3dd_r, c4d_r, c4dd_r, c4ddd_r;
  logic [15:0] lfsr_r;
  logic [21:0] dith;
  logic signed [4:0] y;

  // modulo accumulate: returns carry and residue
  function automatic logic [22:0] mod_add(input logic [21:0] a, input logic [21:0] b,
                                          input logic [21:0] d);
    logic [22:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (d != 22'h0 && s >= {1'b0, d}) begin
      s = s - {1'b0, d};
      return {1'b1, s[21:0]};
    end
    return {1'b0, s[21:0]};
  endfunction

  function automatic logic signed [4:0] sx(input logic b);
    return b ? 5'sh01 : 5'sh00;
  endfunction

  // spur_spread_mode enters the second stage, whose carries are differenced away,
  // so it cannot bias the average ratio; values not below the modulus are dropped
  always_comb begin
    case (spread)
      FSDC_SPR_WEAK: dith = {21'h0, lfsr_r[0]};
      FSDC_SPR_STRONG: dith = {20'h0, lfsr_r[1:0]};
      default: dith = 22'h0;
    endcase
    if (dith >= denom) begin
      dith = 22'h0;
    end
  end

  always_comb begin
    logic [22:0] r;
    logic [21:0] b;
    r = 23'h0;
    b = num;
    for (int i = 0; i < 4; i++) begin
      r = mod_add(acc_r[i], b, denom);
      acc_nxt[i] = r[21:0];
      cy[i] = r[22];
      b = r[21:0];
      if (i == 0) begin
        r = mod_add(b, dith, denom);
        b = r[21:0];
      end
    end
  end

  // higher stages are cancelled by differencing; order masks them
  always_comb begin
    y = sx(cy[0]) + sx(cy[1]) - sx(c2d_r);
    if (ordr == FSDC_ORD_THIRD || ordr == FSDC_ORD_FOURTH) begin
      y = y + sx(cy[2]) - sx(c3d_r) - sx(c3d_r) + sx(c3dd_r);
    end
    if (ordr == FSDC_ORD_FOURTH) begin
      y = y + sx(cy[3]) - sx(c4d_r) - sx(c4d_r) - sx(c4d_r)
            + sx(c4dd_r) + sx(c4dd_r) + sx(c4dd_r) - sx(c4ddd_r);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || ordr == FSDC_ORD_RESET) begin
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= 22'h0;
      end
      {c2d_r, c3d_r, c3dd_r, c4d_r, c4dd_r, c4ddd_r} <= 6'h0;
      offset <= 5'sh00;
    end else if (step) begin
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= acc_nxt[i];
      end
      c2d_r <= cy[1];
      c3d_r <= cy[2];
      c3dd_r <= c3d_r;
      c4d_r <= cy[3];
      c4dd_r <= c4d_r;
      c4ddd_r <= c4dd_r;
      offset <= y;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lfsr_r <= 16'hace1;
    end else if (step) begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  AST_RESET_ZERO: assert property (@(posedge clk) disable iff (reset)
    ordr == FSDC_ORD_RESET |=> offset == 5'sh00)
    else $error("offset not zero in integer mode");
endmodule
`default_nettype wire

// >>> design/fsdc_top.sv
// control bank and digital loop logic of a fractional-n synthesizer
// ------------------------------------------------------------
// How it works
// - the 4-bit pump current code k selects (k+1) times a 90 uA unit, up to 1440 uA.
// - the reference input is divided by the 6-bit reference divide field to make the comparison pulse.
// - the 22-bit denominator joins 12 low bits from the second word and 10 high bits from the third.
// - wide mode uses full 22-bit numerator and denominator, otherwise only their low 12 bits.
// - numerator high 10 bits and integer divider high 3 bits come from the first word.
// - the order field picks fourth, reset/integer, second or third order modulation.
// - the spread field picks weak spur_spread_mode, reserved, strong spur_spread_mode or no spur_spread_mode.
// - the test pin select drives the test/lock pin per its code, reserved codes float.
// - digital lock code drives the pin high while locked and low otherwise.
// - analog lock codes pull the pin low while the pump is active; push-pull drives it high otherwise, open drain lets it float.
// - the output-halve bit divides the oscillator output by two.
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "fsdc_defs.svh"
module fsdc_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REF_OSC_INPUT,
  input wire logic VCO_IN,
  input wire logic [7:0] N_LOW,
  input wire logic [11:0] NUM_LOW,
  output logic VCO_OUT,
  output logic [10:0] PUMP_CURRENT_UA,
  output logic [11:0] FB_DIVIDE,
  output logic TEST_LOCK_PIN_O,
  output logic TEST_LOCK_PIN_OE
);
  import fsdc_pkg::*;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic [23:0] word_a_r, word_b_r, word_c_r;
  logic setup, access, wr_ok, mapped;
  logic locked_r, pump_active;

  function automatic logic is_mapped(input logic [7:0] a, input logic wr);
    case (a)
      `FSDC_OFS_WORD_A, `FSDC_OFS_WORD_B, `FSDC_OFS_WORD_C: return 1'b1;
      `FSDC_OFS_STATUS: return !wr;
      default: return 1'b0;
    endcase
  endfunction

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign mapped = is_mapped(PADDR, PWRITE);
  assign wr_ok = access && PWRITE && mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;

  // a word is taken whole at the access edge only
  always_ff @(posedge CLK) begin
    if (RESET) begin
      word_a_r <= `FSDC_WORD_A_RST;
      word_b_r <= `FSDC_WORD_B_RST;
      word_c_r <= `FSDC_WORD_C_RST;
    end else if (wr_ok) begin
      case (PADDR)
        `FSDC_OFS_WORD_A: word_a_r <= PWDATA[23:0];
        `FSDC_OFS_WORD_B: word_b_r <= PWDATA[23:0];
        `FSDC_OFS_WORD_C: word_c_r <= PWDATA[23:0];
        default: word_a_r <= word_a_r;
      endcase
    end
  end

  // words are write-only; status shows lock and pump activity
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= 32'h0;
    end else if (setup) begin
      PRDATA <= (PADDR == `FSDC_OFS_STATUS && !PWRITE) ?
                {30'h0, pump_active, locked_r} : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  logic [3:0] pump_current_code;
  logic [2:0] n_high;
  logic [9:0] num_high, denom_high;
  logic [11:0] denom_low;
  logic [5:0] rdiv;
  logic output_halve, wide_fraction_mode;
  fsdc_spread_t spur_spread_mode;
  fsdc_order_t ordr;
  fsdc_tsel_t test_pin_select;
  logic [10:0] n_full;
  logic [21:0] num_eff, frac_denominator;

  assign pump_current_code = word_a_r[`FSDC_PUMP_LSB +: 4];
  assign n_high = word_a_r[`FSDC_NHI_LSB +: 3];
  assign num_high = word_a_r[`FSDC_NUMHI_LSB +: 10];
  assign denom_low = word_b_r[`FSDC_DENLO_LSB +: 12];
  assign rdiv = word_b_r[`FSDC_RDIV_LSB +: 6];
  assign output_halve = word_c_r[`FSDC_HALVE_BIT];
  assign wide_fraction_mode = word_c_r[`FSDC_WIDE_BIT];
  assign spur_spread_mode = fsdc_spread_t'(word_c_r[`FSDC_SPREAD_LSB +: 2]);
  assign ordr = fsdc_order_t'(word_c_r[`FSDC_ORDER_LSB +: 2]);
  assign test_pin_select = fsdc_tsel_t'(word_c_r[`FSDC_TSEL_LSB +: 4]);
  assign denom_high = word_c_r[`FSDC_DENHI_LSB +: 10];

  assign n_full = {n_high, N_LOW};
  // narrow mode drops the high parts of both fraction words
  assign num_eff = wide_fraction_mode ? {num_high, NUM_LOW} : {10'h0, NUM_LOW};
  assign frac_denominator = wide_fraction_mode ? {denom_high, denom_low}
                                               : {10'h0, denom_low};

  // ------------------------------------------------------------
  // pump current
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PUMP_CURRENT_UA <= `FSDC_PUMP_UNIT_UA;
    end else begin
      PUMP_CURRENT_UA <= 11'({7'h0, pump_current_code} + 11'h1) * `FSDC_PUMP_UNIT_UA;
    end
  end

  // ------------------------------------------------------------
  // reference divider
  // ------------------------------------------------------------
  logic ref_d_r, ref_rise, ref_pulse;
  logic [5:0] ref_cnt_r;

  assign ref_rise = REF_OSC_INPUT && !ref_d_r;
  // a zero field counts as one so the loop never starves; host keeps it legal
  assign ref_pulse = ref_rise && (rdiv == 6'h0 || ref_cnt_r >= rdiv - 6'h1);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ref_d_r <= 1'b0;
      ref_cnt_r <= 6'h0;
    end else begin
      ref_d_r <= REF_OSC_INPUT;
      if (ref_pulse) begin
        ref_cnt_r <= 6'h0;
      end else if (ref_rise) begin
        ref_cnt_r <= ref_cnt_r + 6'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // feedback divider and modulator
  // ------------------------------------------------------------
  logic vco_d_r, vco_rise, fb_pulse;
  logic [11:0] fb_cnt_r, n_next, n_sum;
  logic signed [4:0] mod_offset;

  fsdc_dsm fsdc_dsm_inst (
    .clk(CLK),
    .reset(RESET),
    .step(fb_pulse),
    .num(num_eff),
    .denom(frac_denominator),
    .ordr(ordr),
    .spread(spur_spread_mode),
    .offset(mod_offset)
  );

  assign vco_rise = VCO_IN && !vco_d_r;
  assign fb_pulse = vco_rise && (fb_cnt_r >= FB_DIVIDE - 12'h1);
  // instantaneous divide is integer plus modulator offset, floored at one
  assign n_sum = {1'b0, n_full} + {{7{mod_offset[4]}}, mod_offset};
  assign n_next = (n_sum[11] || n_sum == 12'h0) ? 12'h1 : n_sum;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      vco_d_r <= 1'b0;
      fb_cnt_r <= 12'h0;
      FB_DIVIDE <= `FSDC_FB_DIV_RST;
    end else begin
      vco_d_r <= VCO_IN;
      if (fb_pulse) begin
        fb_cnt_r <= 12'h0;
        FB_DIVIDE <= n_next;
      end else if (vco_rise) begin
        fb_cnt_r <= fb_cnt_r + 12'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // phase detector and lock detect
  // ------------------------------------------------------------
  logic up_r, dn_r;
  logic [7:0] err_cnt_r;
  logic [3:0] good_cnt_r;

  // classic two-flop detector: pump runs from the first edge to the second
  always_ff @(posedge CLK) begin
    if (RESET) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else if ((up_r || ref_pulse) && (dn_r || fb_pulse)) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else begin
      up_r <= up_r || ref_pulse;
      dn_r <= dn_r || fb_pulse;
    end
  end

  assign pump_active = up_r || dn_r;

  // lock is declared after a run of comparison cycles with short pump time
  always_ff @(posedge CLK) begin
    if (RESET) begin
      err_cnt_r <= 8'h0;
      good_cnt_r <= 4'h0;
      locked_r <= 1'b0;
    end else if (ref_pulse) begin
      err_cnt_r <= 8'h0;
      if (err_cnt_r > `FSDC_LOCK_WIN) begin
        good_cnt_r <= 4'h0;
        locked_r <= 1'b0;
      end else if (good_cnt_r == `FSDC_LOCK_CNT) begin
        locked_r <= 1'b1;
      end else begin
        good_cnt_r <= good_cnt_r + 4'h1;
      end
    end else if (pump_active && err_cnt_r != 8'hff) begin
      err_cnt_r <= err_cnt_r + 8'h1;
    end
  end

  // ------------------------------------------------------------
  // test/lock pin and output halving
  // ------------------------------------------------------------
  logic fb_half_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      fb_half_r <= 1'b0;
    end else if (fb_pulse) begin
      fb_half_r <= !fb_half_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      TEST_LOCK_PIN_O <= 1'b0;
      TEST_LOCK_PIN_OE <= 1'b0;
    end else begin
      TEST_LOCK_PIN_O <= 1'b0;
      TEST_LOCK_PIN_OE <= 1'b1;
      case (test_pin_select)
        FSDC_TP_HIGH: TEST_LOCK_PIN_O <= 1'b1;
        FSDC_TP_LOW: TEST_LOCK_PIN_O <= 1'b0;
        FSDC_TP_DLOCK: TEST_LOCK_PIN_O <= locked_r;
        FSDC_TP_FBHALF: TEST_LOCK_PIN_O <= fb_half_r;
        FSDC_TP_ALOCK_OD: TEST_LOCK_PIN_OE <= pump_active;
        FSDC_TP_ALOCK_PP: TEST_LOCK_PIN_O <= !pump_active;
        FSDC_TP_REFOUT: TEST_LOCK_PIN_O <= ref_pulse;
        default: TEST_LOCK_PIN_OE <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      VCO_OUT <= 1'b0;
    end else if (output_halve) begin
      if (vco_rise) begin
        VCO_OUT <= !VCO_OUT;
      end
    end else begin
      VCO_OUT <= VCO_IN;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  AST_PUMP_LEVEL: assert property (
    ##1 PUMP_CURRENT_UA == 11'(($past(pump_current_code) + 5'h1) * 7'd90))
    else $error("pump current not matching code");
  AST_REF_DIVIDE: assert property (
    ref_pulse && rdiv == 6'h4 |=> (!ref_pulse || rdiv != 6'h4) [*5])
    else $error("reference pulse spacing wrong");
  AST_NARROW_DEN: assert property (
    !wide_fraction_mode |-> frac_denominator[21:12] == 10'h0 && num_eff[21:12] == 10'h0)
    else $error("high fraction bits used in narrow mode");
  AST_WIDE_DEN: assert property (
    wide_fraction_mode |-> frac_denominator == {word_c_r[13:4], word_b_r[21:10]})
    else $error("wide denominator not assembled");
  AST_INT_RATIO: assert property (
    fb_pulse && ordr == FSDC_ORD_RESET && $past(ordr) == FSDC_ORD_RESET
    |=> FB_DIVIDE == ($past(n_full) == 11'h0 ? 12'h1 : {1'b0, $past(n_full)}))
    else $error("integer mode ratio wrong");
  AST_TP_FLOAT: assert property (
    test_pin_select == FSDC_TP_HIZ |=> !TEST_LOCK_PIN_OE)
    else $error("test pin driven while disabled");
  AST_TP_DLOCK: assert property (
    test_pin_select == FSDC_TP_DLOCK |=> TEST_LOCK_PIN_OE && TEST_LOCK_PIN_O == $past(locked_r))
    else $error("digital lock output wrong");
  AST_TP_ALOCK: assert property (
    test_pin_select == FSDC_TP_ALOCK_PP && pump_active |=> TEST_LOCK_PIN_O == 1'b0)
    else $error("analog lock pulse missing");
  AST_HALVE: assert property (
    output_halve && $past(output_halve) && vco_rise |=> VCO_OUT != $past(VCO_OUT))
    else $error("halved output did not toggle");
  AST_WORD_HOLD: assert property (
    !(access && PWRITE) |=> $stable(word_a_r) && $stable(word_b_r) && $stable(word_c_r))
    else $error("word changed without a complete write");
  AST_TP_REFOUT: assert property (
    test_pin_select == FSDC_TP_REFOUT |=> TEST_LOCK_PIN_OE && TEST_LOCK_PIN_O == $past(ref_pulse))
    else $error("reference output not on test pin");
  AST_FB_HALF: assert property (
    fb_pulse |=> fb_half_r != $past(fb_half_r))
    else $error("halved feedback output did not toggle");
  AST_LOCK_DROP: assert property (
    ref_pulse && err_cnt_r > `FSDC_LOCK_WIN |=> !locked_r)
    else $error("lock kept after a long pump interval");

  COV_LOCKED: cover property (!locked_r ##1 locked_r);
  COV_UNMAPPED: cover property (PSLVERR);
  COV_WIDE_STEP: cover property (wide_fraction_mode && ordr == FSDC_ORD_FOURTH && fb_pulse);
  COV_OPEN_DRAIN: cover property (test_pin_select == FSDC_TP_ALOCK_OD && pump_active);
endmodule
`default_nettype wire

// >>> bench/fsdc_osc_model.sv
// reference and oscillator edge source standing in for the analog side of the loop
`timescale 1ns/1ps
`default_nettype none
module fsdc_osc_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] ref_half,
  input wire logic [7:0] vco_half,
  output logic ref_osc,
  output logic vco
);
  logic [7:0] ref_cnt_r;
  logic [7:0] vco_cnt_r;

  // ------------------------------------------------------------
  // square waves, both restart low together so their edges line up
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!run) begin
      ref_cnt_r <= 8'h00;
      ref_osc <= 1'b0;
    end else if (ref_cnt_r + 8'h01 >= ref_half) begin
      ref_cnt_r <= 8'h00;
      ref_osc <= !ref_osc;
    end else begin
      ref_cnt_r <= ref_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!run) begin
      vco_cnt_r <= 8'h00;
      vco <= 1'b0;
    end else if (vco_cnt_r + 8'h01 >= vco_half) begin
      vco_cnt_r <= 8'h00;
      vco <= !vco;
    end else begin
      vco_cnt_r <= vco_cnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> bench/frac_synth_divider_control_tb.sv
// self-checking bench for the synthesizer control bank
`timescale 1ns/1ps
`default_nettype none
`include "fsdc_defs.svh"
module frac_synth_divider_control_tb;
  import fsdc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] n_low = 8'h20;
  logic [11:0] num_low = 12'h001;
  logic run = 1'b0;
  logic [7:0] ref_half = 8'h02;
  logic [7:0] vco_half = 8'h01;
  wire logic ref_osc, vco_in, vco_out, pin_o, pin_oe, pready, pslverr;
  wire logic [31:0] prdata;
  wire logic [10:0] pump_ua;
  wire logic [11:0] fb_div;
  int err_count = 0;
  int total_checks = 0;
  int cp, cvi, cvo, clo, coe, s;
  logic [31:0] rd;
  logic err;
  logic [3:0] tcode [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
  logic [1:0] ord_t [6] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h1, 2'h2};
  logic [1:0] spr_t [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};

  fsdc_top fsdc_top_inst (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .REF_OSC_INPUT(ref_osc), .VCO_IN(vco_in), .N_LOW(n_low),
    .NUM_LOW(num_low), .VCO_OUT(vco_out), .PUMP_CURRENT_UA(pump_ua), .FB_DIVIDE(fb_div),
    .TEST_LOCK_PIN_O(pin_o), .TEST_LOCK_PIN_OE(pin_oe));

  fsdc_osc_model fsdc_osc_model_inst (.clk(clk), .run(run), .ref_half(ref_half),
    .vco_half(vco_half), .ref_osc(ref_osc), .vco(vco_in));

  always #2.5 clk = ~clk;

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_near(input string nm, input int exp, input int got, input int tol);
    total_checks++;
    if (got > exp + tol || got < exp - tol) begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  // ------------------------------------------------------------
  // bus cycles and word builders
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      err_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] wa(input logic [3:0] k, input logic [2:0] nh,
                                     input logic [9:0] mh);
    return 32'h00200001 | (32'(k) << `FSDC_PUMP_LSB) | (32'(nh) << `FSDC_NHI_LSB)
      | (32'(mh) << `FSDC_NUMHI_LSB);
  endfunction

  function automatic logic [31:0] wb(input logic [11:0] dl, input logic [5:0] rdv);
    return 32'h00400002 | (32'(dl) << `FSDC_DENLO_LSB) | (32'(rdv) << `FSDC_RDIV_LSB);
  endfunction

  function automatic logic [31:0] wc(input logic h, input logic w, input logic [1:0] sp,
                                     input logic [1:0] od, input logic [3:0] ts,
                                     input logic [9:0] dh);
    return 32'h00000003 | (32'(h) << `FSDC_HALVE_BIT) | (32'(w) << `FSDC_WIDE_BIT)
      | (32'(sp) << `FSDC_SPREAD_LSB) | (32'(od) << `FSDC_ORDER_LSB)
      | (32'(ts) << `FSDC_TSEL_LSB) | (32'(dh) << `FSDC_DENHI_LSB);
  endfunction

  // counts edges and levels seen at the outputs over n cycles
  task automatic window(input int n);
    logic p0, v0, o0;
    cp = 0; cvi = 0; cvo = 0; clo = 0; coe = 0;
    p0 = pin_o; v0 = vco_in; o0 = vco_out;
    repeat (n) begin
      @(posedge clk);
      cp += int'(pin_o & !p0);
      cvi += int'(vco_in & !v0);
      cvo += int'(vco_out & !o0);
      clo += int'(!pin_o);
      coe += int'(pin_oe);
      p0 = pin_o; v0 = vco_in; o0 = vco_out;
    end
  endtask

  // sums oscillator rises over n feedback periods, marked by test pin toggles
  task automatic fb_sum(input int n);
    logic p0, v0;
    int k, t;
    s = 0; k = 0; t = 0;
    p0 = pin_o; v0 = vco_in;
    while (k <= n && t < 20000) begin
      @(posedge clk);
      t++;
      if (k > 0) s += int'(vco_in & !v0);
      if (pin_o !== p0) k++;
      p0 = pin_o; v0 = vco_in;
    end
    if (t >= 20000) begin
      err_count++;
      finish_test();
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("pump reset", 32'd90, 32'(pump_ua));
    chk("fb reset", 32'h037, 32'(fb_div));
    chk("pin oe reset", 32'h0, 32'(pin_oe));
    run <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, `FSDC_OFS_WORD_A, wa(4'(k), 3'h0, 10'h0));
      repeat (2) @(posedge clk);
      chk("pump current", 32'((k + 1) * 90), 32'(pump_ua));
    end
    apb(1'b1, `FSDC_OFS_STATUS, wa(4'h0, 3'h0, 10'h0));
    chk("status write err", 32'h1, 32'(err));
    repeat (2) @(posedge clk);
    chk("pump kept", 32'd1440, 32'(pump_ua));
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, `FSDC_OFS_WORD_A, 32'h0);
    chk("word read data", 32'h0, rd);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `FSDC_OFS_WORD_C, wc(1'b0, 1'b0, 2'h3, 2'h1, tcode[i], 10'h0));
      repeat (3) @(posedge clk);
      chk("pin oe", 32'(tcode[i] == 4'h1 || tcode[i] == 4'h2), 32'(pin_oe));
      if (tcode[i] == 4'h1 || tcode[i] == 4'h2)
        chk("pin level", 32'(tcode[i] == 4'h1), 32'(pin_o));
    end
    apb(1'b1, `FSDC_OFS_WORD_C, wc(1'b0, 1'b0, 2'h3, 2'h1, 4'he, 10'h0));
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `FSDC_OFS_WORD_B, wb(12'h000, 6'(1 << i)));
      window(512);
      chk_near("ref pulses", 128 >> i, cp, 1);
    end
    for (int h = 0; h < 2; h++) begin
      apb(1'b1, `FSDC_OFS_WORD_C, wc(h[0], 1'b0, 2'h3, 2'h1, 4'h0, 10'h0));
      repeat (4) @(posedge clk);
      window(400);
      chk_near("vco out rises", cvi >> h, cvo, 1);
    end
    n_low <= 8'h00;
    apb(1'b1, `FSDC_OFS_WORD_A, wa(4'h0, 3'h1, 10'h0));
    repeat (1200) @(posedge clk);
    chk("fb int high", 32'h100, 32'(fb_div));
    n_low <= 8'h20;
    apb(1'b1, `FSDC_OFS_WORD_A, wa(4'h0, 3'h0, 10'h5));
    repeat (800) @(posedge clk);
    chk("fb int low", 32'h020, 32'(fb_div));
    apb(1'b1, `FSDC_OFS_WORD_B, wb(12'h002, 6'h01));
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `FSDC_OFS_WORD_C, wc(1'b0, 1'b0, spr_t[i], ord_t[i], 4'h5, 10'h3));
      fb_sum(60);
      chk_near("narrow sum", ord_t[i] == 2'h1 ? 1920 : 1950, s, 8);
    end
    apb(1'b1, `FSDC_OFS_WORD_A, wa(4'h0, 3'h0, 10'h0));
    apb(1'b1, `FSDC_OFS_WORD_C, wc(1'b0, 1'b1, 2'h3, 2'h2, 4'h5, 10'h1));
    fb_sum(60);
    chk_near("wide sum", 1920, s, 8);
    ref_half <= 8'h04;
    vco_half <= 8'h04;
    run <= 1'b0;
    n_low <= 8'h01;
    num_low <= 12'h000;
    apb(1'b1, `FSDC_OFS_WORD_B, wb(12'h000, 6'h01));
    apb(1'b1, `FSDC_OFS_WORD_C, wc(1'b0, 1'b0, 2'h3, 2'h1, 4'h3, 10'h0));
    run <= 1'b1;
    repeat (600) @(posedge clk);
    chk("locked pin", 32'h1, {31'h0, pin_o});
    chk("locked oe", 32'h1, {31'h0, pin_oe});
    apb(1'b0, `FSDC_OFS_STATUS, 32'h0);
    chk("status locked", 32'h1, {31'h0, rd[0]});
    n_low <= 8'h02;
    repeat (300) @(posedge clk);
    chk("unlocked pin", 32'h0, {31'h0, pin_o});
    apb(1'b1, `FSDC_OFS_WORD_C, wc(1'b0, 1'b0, 2'h3, 2'h1, 4'h7, 10'h0));
    repeat (4) @(posedge clk);
    window(200);
    chk("alock low pulses", 32'h1, 32'(clo > 0 && clo < 200));
    chk("alock pp oe", 32'd200, 32'(coe));
    apb(1'b1, `FSDC_OFS_WORD_C, wc(1'b0, 1'b0, 2'h3, 2'h1, 4'h6, 10'h0));
    repeat (4) @(posedge clk);
    window(200);
    chk("alock od level", 32'd200, 32'(clo));
    chk("alock od oe", 32'h1, 32'(coe > 0 && coe < 200));
    finish_test();
  end
endmodule
`default_nettype wire
